// ===== rtl/dss_defs.svh
// constants for the drive safety supervisor: codes, reset values, timing
`ifndef DSS_DEFS_SVH
`define DSS_DEFS_SVH

// safety input function selection
`define DSS_IN_DISABLED      2'h0
`define DSS_IN_CUTOFF        2'h1
`define DSS_IN_TIMED         2'h2
`define DSS_IN_FUNC_RST      2'h0

// external fault reaction
`define DSS_EXT_CUTOFF       1'h0
`define DSS_EXT_TIMED        1'h1

// reset source selection
`define DSS_RSRC_PANEL       2'h0
`define DSS_RSRC_DIN         2'h1
`define DSS_RSRC_BUS         2'h2

// register byte offsets
`define DSS_OFF_CTRL         12'h000
`define DSS_OFF_DELAY        12'h004
`define DSS_OFF_STATUS       12'h008
`define DSS_OFF_CMD          12'h00C

// control register fields
`define DSS_CTRL_FUNC_LSB    0
`define DSS_CTRL_BUS_EN      2
`define DSS_CTRL_AUTO        3
`define DSS_CTRL_EXTR        4
`define DSS_CTRL_RSRC_LSB    5

// command register fields (write one to act)
`define DSS_CMD_ALARM_CLR    0
`define DSS_CMD_RESET        1

// timed stop delay default, in milliseconds, and clock rate
`define DSS_DELAY_MS_RST     32'h0000_03E8
`define DSS_CLK_HZ           40000000
`define DSS_MS_CYCLES        (`DSS_CLK_HZ / 1000)

`endif

// ===== rtl/dss_pkg.sv
// types shared by the drive safety supervisor
package dss_pkg;

    typedef enum logic [1:0] {
        DSS_RUN,
        DSS_TIMED,
        DSS_CUTOFF,
        DSS_WAIT_RESET
    } dss_state_t;

endpackage : dss_pkg

// ===== rtl/dss_ms_tick.sv
// millisecond enable pulse divider
`timescale 1ns/1ps
`include "dss_defs.svh"

module dss_ms_tick
    import dss_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic restart,
    output logic      tick
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } dss_tick_t;

    localparam logic [15:0] LAST = 16'(`DSS_MS_CYCLES - 1);

    dss_tick_t s_reg;
    dss_tick_t s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.tick = 1'b0;
        if (restart) begin
            s_next.cnt = 16'h0000;
        end else if (s_reg.cnt == LAST) begin
            s_next.cnt  = 16'h0000;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

endmodule : dss_ms_tick

// ===== rtl/dss_top.sv
// drive safety supervisor: source selection, fault reaction, recovery
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "dss_defs.svh"

module dss_top
    import dss_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // redundant safety input, active high means released
    input  wire logic        safe_in_a,
    input  wire logic        safe_in_b,
    // safety fieldbus commands
    input  wire logic        bus_cutoff_req,
    input  wire logic        bus_timed_req,
    input  wire logic        bus_comm_err,
    input  wire logic        bus_force_safe,
    // reset sources and faults
    input  wire logic        local_panel_reset,
    input  wire logic        din_reset,
    input  wire logic        plain_bus_reset,
    input  wire logic        internal_fault,
    // power stage and status
    output logic             gate_hi_supply_en,
    output logic             gate_lo_supply_en,
    output logic             torque_cutoff,
    output logic             timed_stop_then_cutoff,
    output logic             alarm,
    output logic             ext_fault
);

    typedef struct packed {
        dss_state_t  st;
        logic [1:0]  func;
        logic        bus_en;
        logic        auto_rst;
        logic        ext_react;
        logic [1:0]  rsrc;
        logic [31:0] delay_ms;
        logic [31:0] remain;
        logic        alarm;
        logic        ext;
        logic        manual;
        logic        tmr_run;
        logic        gate_on;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } dss_s_t;

    dss_s_t s_reg;
    dss_s_t s_next;
    logic   tick;

    // one decode per register offset, shared by the error flag
    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == `DSS_OFF_CTRL) || (a == `DSS_OFF_DELAY) ||
                  (a == `DSS_OFF_STATUS) || (a == `DSS_OFF_CMD);
    endfunction : addr_ok

    // a write lands only in the access phase, never in setup, so a
    // transfer that is abandoned after setup changes nothing
    function automatic logic wr_hit(input logic        sel,
                                    input logic        en,
                                    input logic        w,
                                    input logic [11:0] a,
                                    input logic [11:0] off);
        wr_hit = sel && en && w && (a == off);
    endfunction : wr_hit

    // the gate supply stays on only while the motor may still move;
    // every other state is the safe state
    function automatic logic drives_motor(input dss_state_t st);
        drives_motor = (st == DSS_RUN) || (st == DSS_TIMED);
    endfunction : drives_motor

    // only the selected source may acknowledge; the others are ignored
    // and a reset written over the register bus is added by the caller
    function automatic logic pick_reset(input logic [1:0] src,
                                        input logic       panel,
                                        input logic       din,
                                        input logic       plain_bus);
        case (src)
            `DSS_RSRC_PANEL: pick_reset = panel;
            `DSS_RSRC_DIN:   pick_reset = din;
            `DSS_RSRC_BUS:   pick_reset = plain_bus;
            default:         pick_reset = 1'b0;
        endcase
    endfunction : pick_reset

    // read word for one register; unmapped offsets read as zero
    function automatic logic [31:0] read_word(input logic [11:0] a,
                                              input dss_s_t      s);
        case (a)
            `DSS_OFF_CTRL: begin
                read_word = {25'h0000000,
                             s.rsrc,
                             s.ext_react,
                             s.auto_rst,
                             s.bus_en,
                             s.func};
            end
            `DSS_OFF_DELAY: begin
                read_word = s.delay_ms;
            end
            `DSS_OFF_STATUS: begin
                read_word = {24'h000000,
                             s.manual,
                             s.ext,
                             s.alarm,
                             s.gate_on,
                             2'h0,
                             s.st};
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    endfunction : read_word

    // the divider restarts outside timed stop so the first millisecond of
    // a new delay is a whole one, not a fragment of an older count
    dss_ms_tick u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (s_reg.st != DSS_TIMED),
        .tick    (tick)
    );

    // ------------------------------------------------------------------
    // trigger evaluation
    // ------------------------------------------------------------------
    logic in_en;
    logic in_low;
    logic in_mis;
    logic in_cut;
    logic in_tim;
    logic bc;
    logic bt;
    logic ext_now;
    logic rst_now;
    logic cut_req;
    logic tim_req;
    logic rd;
    logic ctrl_hit;
    logic delay_hit;
    logic cmd_hit;
    logic clr_hit;

    always_comb begin
        in_en   = (s_reg.func != `DSS_IN_DISABLED);
        in_low  = in_en && !(safe_in_a && safe_in_b);
        in_mis  = in_en && (safe_in_a != safe_in_b);
        in_cut  = in_low && (s_reg.func == `DSS_IN_CUTOFF);
        in_tim  = in_low && (s_reg.func == `DSS_IN_TIMED);
        bc      = s_reg.bus_en && bus_cutoff_req;
        bt      = s_reg.bus_en && bus_timed_req;
        ext_now = in_mis ||
                  (s_reg.bus_en && (bus_comm_err || bus_force_safe));
        rst_now = pick_reset(s_reg.rsrc, local_panel_reset,
                             din_reset, plain_bus_reset);
        // register writes take effect only at the access edge
        rd        = psel && !penable && !pwrite;
        ctrl_hit  = wr_hit(psel, penable, pwrite, paddr, `DSS_OFF_CTRL);
        delay_hit = wr_hit(psel, penable, pwrite, paddr, `DSS_OFF_DELAY);
        cmd_hit   = wr_hit(psel, penable, pwrite, paddr, `DSS_OFF_CMD);
        clr_hit   = cmd_hit && pwdata[`DSS_CMD_ALARM_CLR];
        // a reset written over the register bus acts like any source
        if (cmd_hit && pwdata[`DSS_CMD_RESET]) begin
            rst_now = 1'b1;
        end
        // external faults follow the selected reaction; internal is cutoff
        cut_req = in_cut || bc || internal_fault ||
                  (ext_now && s_reg.ext_react == `DSS_EXT_CUTOFF);
        tim_req = in_tim || bt ||
                  (ext_now && s_reg.ext_react == `DSS_EXT_TIMED);
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_next         = s_reg;
        s_next.pready  = 1'b0;
        s_next.pslverr = 1'b0;

        // ------------------------------------------------------------------
        // alarm and fault latches
        // ------------------------------------------------------------------
        // set is applied after clear, so a fault in the clear cycle wins
        if (clr_hit) begin
            s_next.alarm = 1'b0;
        end
        if (internal_fault) begin
            s_next.alarm = 1'b1;
        end
        if (ext_now) begin
            s_next.ext = 1'b1;
        end
        // input trigger in manual mode needs acknowledgement
        if ((in_cut || in_tim) && !s_reg.auto_rst) begin
            s_next.manual = 1'b1;
        end

        // ------------------------------------------------------------------
        // supervisor state machine
        // ------------------------------------------------------------------
        case (s_reg.st)
            DSS_RUN: begin
                if (cut_req || s_reg.alarm) begin
                    s_next.st = DSS_CUTOFF;
                end else if (tim_req) begin
                    s_next.st     = DSS_TIMED;
                    s_next.remain = s_reg.delay_ms;
                end
            end
            DSS_TIMED: begin
                if (cut_req || s_reg.alarm) begin
                    s_next.st = DSS_CUTOFF;
                end else if (s_reg.remain == 32'h0000_0000) begin
                    s_next.st = DSS_CUTOFF;
                end else if (!tim_req && !s_reg.ext && !s_reg.manual) begin
                    s_next.st = DSS_RUN;
                end else if (tick) begin
                    s_next.remain = s_reg.remain - 32'h0000_0001;
                end
            end
            DSS_CUTOFF: begin
                // timed request still asserted keeps cutoff latched
                if (!cut_req && !tim_req && !s_reg.alarm) begin
                    if (s_reg.ext || s_reg.manual) begin
                        s_next.st = DSS_WAIT_RESET;
                    end else begin
                        s_next.st = DSS_RUN;
                    end
                end
            end
            DSS_WAIT_RESET: begin
                if (cut_req || tim_req || s_reg.alarm) begin
                    s_next.st = DSS_CUTOFF;
                end else if (rst_now) begin
                    s_next.st     = DSS_RUN;
                    s_next.ext    = 1'b0;
                    s_next.manual = 1'b0;
                end
            end
            default: begin
                s_next.st = DSS_CUTOFF;
            end
        endcase

        // ------------------------------------------------------------------
        // power stage flags
        // ------------------------------------------------------------------
        // both follow the next state so the outputs change in the same
        // cycle as the state itself, one cycle after the request
        s_next.gate_on = drives_motor(s_next.st);
        s_next.tmr_run = (s_next.st == DSS_TIMED);

        // ------------------------------------------------------------------
        // apb registers
        // ------------------------------------------------------------------
        if (psel && !penable) begin
            s_next.pready  = 1'b1;
            s_next.pslverr = !addr_ok(paddr);
        end
        if (ctrl_hit) begin
            s_next.func      = pwdata[`DSS_CTRL_FUNC_LSB +: 2];
            s_next.bus_en    = pwdata[`DSS_CTRL_BUS_EN];
            s_next.auto_rst  = pwdata[`DSS_CTRL_AUTO];
            s_next.ext_react = pwdata[`DSS_CTRL_EXTR];
            s_next.rsrc      = pwdata[`DSS_CTRL_RSRC_LSB +: 2];
        end
        if (delay_hit) begin
            s_next.delay_ms = pwdata;
        end
        // read data is captured in setup and stands through the access
        if (rd) begin
            s_next.prdata = read_word(paddr, s_reg);
        end
    end

    // power-up starts in the safe state with a reset already pending
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg          <= '0;
            s_reg.st       <= DSS_CUTOFF;
            s_reg.func     <= `DSS_IN_FUNC_RST;
            s_reg.delay_ms <= `DSS_DELAY_MS_RST;
            s_reg.manual   <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // the safety bus is always off at power-up, so the pending flag makes
    // the first run wait for a reset; turning the bus on later does not
    // clear it, a deliberate simplification
    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata                 = s_reg.prdata;
    assign pready                 = s_reg.pready;
    assign pslverr                = s_reg.pslverr;
    assign gate_hi_supply_en      = s_reg.gate_on;
    assign gate_lo_supply_en      = s_reg.gate_on;
    assign torque_cutoff          = !s_reg.gate_on;
    assign timed_stop_then_cutoff = s_reg.tmr_run;
    assign alarm                  = s_reg.alarm;
    assign ext_fault              = s_reg.ext;

endmodule : dss_top

// ===== testbench/dss_top_assertions.sv
// checker for the drive safety supervisor top ports
`timescale 1ns/1ps
`include "dss_defs.svh"
module dss_checker (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // safety
    input wire logic        internal_fault,
    input wire logic        gate_hi_supply_en,
    input wire logic        gate_lo_supply_en,
    input wire logic        torque_cutoff,
    input wire logic        timed_stop_then_cutoff,
    input wire logic        alarm
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic clr;
    // a clear write lands at the access edge
    assign clr = psel && penable && pwrite && paddr == `DSS_OFF_CMD
                 && pwdata[`DSS_CMD_ALARM_CLR];
    gates_off_a: assert property (
        internal_fault |=> !gate_hi_supply_en && !gate_lo_supply_en)
        else $error("gate supply on during cutoff");
    gate_pair_a: assert property (
        gate_hi_supply_en == gate_lo_supply_en)
        else $error("gate supplies differ");
    fault_trip_a: assert property (
        internal_fault |=> alarm && torque_cutoff)
        else $error("internal fault without alarm and cutoff");
    alarm_hold_a: assert property (
        alarm && !clr |=> alarm)
        else $error("alarm dropped without clear");
    cutoff_wins_a: assert property (
        !(torque_cutoff && timed_stop_then_cutoff))
        else $error("timed stop runs during cutoff");
    apb_ready_a: assert property (
        psel && !penable |=> pready)
        else $error("no ready in access cycle");
    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("ready held two cycles");
    err_ready_a: assert property (
        pslverr |-> pready)
        else $error("error without ready");
endmodule : dss_checker

bind dss_top dss_checker dss_checker_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .internal_fault,
    .gate_hi_supply_en, .gate_lo_supply_en, .torque_cutoff,
    .timed_stop_then_cutoff, .alarm);

// ===== testbench/dss_far_end.sv
// far side: safety fieldbus master and the two input channels
`timescale 1ns/1ps
module dss_far_end (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // wanted levels: force, err, timed, cutoff, b, a
    input  wire logic [5:0] want,
    // lines into the supervisor
    output logic            safe_in_a,
    output logic            safe_in_b,
    output logic            bus_cutoff_req,
    output logic            bus_timed_req,
    output logic            bus_comm_err,
    output logic            bus_force_safe
);
    // telegrams are periodic, so a new command shows on the next edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {bus_force_safe, bus_comm_err} <= 2'h0;
            {bus_timed_req, bus_cutoff_req} <= 2'h0;
            {safe_in_b, safe_in_a} <= 2'h3;
        end else begin
            {bus_force_safe, bus_comm_err} <= want[5:4];
            {bus_timed_req, bus_cutoff_req} <= want[3:2];
            {safe_in_b, safe_in_a} <= want[1:0];
        end
    end
endmodule : dss_far_end

// ===== testbench/dss_top_bench.sv
// self-checking bench for the drive safety supervisor
`timescale 1ns/1ps
`include "dss_defs.svh"
module dss_top_bench;
    import dss_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        safe_in_a, safe_in_b, bus_cutoff_req, bus_timed_req;
    logic        bus_comm_err, bus_force_safe, internal_fault;
    logic        local_panel_reset, din_reset, plain_bus_reset;
    logic        gate_hi_supply_en, gate_lo_supply_en, torque_cutoff;
    logic        timed_stop_then_cutoff, alarm, ext_fault;
    logic [5:0]  want;
    int          err_total, n_checks, c;

    dss_top dss_top_i (.*);
    dss_far_end dss_far_end_i (.*);

    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] ctrl(logic [1:0] f, logic bus, au, ex);
        ctrl = 32'h0;
        ctrl[1:0] = f;
        ctrl[`DSS_CTRL_BUS_EN] = bus;
        ctrl[`DSS_CTRL_AUTO] = au;
        ctrl[`DSS_CTRL_EXTR] = ex;
    endfunction : ctrl

    // callers drive by non-blocking assignment right after the edge and
    // read outputs there, which shows what that edge sampled
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        wt(1);
    endtask : apb

    task automatic ck(input logic [32:0] g, e, input string m);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : ck

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    // watchdog: the timed stop alone takes about 40000 cycles
    initial begin
        repeat (60000) @(posedge pclk);
        err_total++;
        $display("mismatch at %0t: watchdog", $time);
        close_out;
    end

    initial begin
        {presetn, psel, penable, pwrite, internal_fault} = 5'h0;
        {local_panel_reset, din_reset, plain_bus_reset} = 3'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        want = 6'h03;
        void'($urandom(32'h5486));
        wt(6);
        presetn <= 1'h1;
        wt(1);
        ck(torque_cutoff, 1'h1, "power-up cutoff");
        apb(1'h0, `DSS_OFF_CTRL, 32'h0);
        ck(rd, 32'h0, "control reset");
        apb(1'h0, `DSS_OFF_DELAY, 32'h0);
        ck(rd, `DSS_DELAY_MS_RST, "delay reset");
        apb(1'h0, 12'h010, 32'h0);
        ck({er, rd}, 33'h1_0000_0000, "unmapped read");
        apb(1'h1, `DSS_OFF_CMD, 32'h2);
        wt(3);
        ck(gate_hi_supply_en, 1'h1, "run after reset");
        $display("test reset done");
        repeat (30) begin
            want <= {2'h0, 4'($urandom)};
            wt(1);
            ck(torque_cutoff, 1'h0, "reacted while off");
        end
        want <= 6'h03;
        apb(1'h1, `DSS_OFF_CTRL, ctrl(`DSS_IN_CUTOFF, 1'h0, 1'h1, 1'h0));
        want <= 6'h00;
        wt(3);
        ck({torque_cutoff, gate_hi_supply_en}, 2'h2, "input cutoff");
        ck(gate_lo_supply_en, 1'h0, "low side cut");
        want <= 6'h03;
        wt(3);
        ck(torque_cutoff, 1'h0, "auto restart");
        apb(1'h1, `DSS_OFF_CTRL, ctrl(`DSS_IN_CUTOFF, 1'h1, 1'h1, 1'h0));
        want <= 6'h0B;
        wt(3);
        ck({torque_cutoff, timed_stop_then_cutoff}, 2'h1, "bus timed");
        want <= 6'h0F;
        wt(3);
        ck({torque_cutoff, timed_stop_then_cutoff}, 2'h2, "preempt");
        want <= 6'h03;
        wt(3);
        ck(torque_cutoff, 1'h0, "bus inactive");
        $display("test sources done");
        apb(1'h1, `DSS_OFF_DELAY, 32'h1);
        apb(1'h1, `DSS_OFF_CTRL, ctrl(`DSS_IN_TIMED, 1'h0, 1'h0, 1'h0));
        want <= 6'h00;
        wt(3);
        ck(timed_stop_then_cutoff, 1'h1, "timed start");
        c = 0;
        while (torque_cutoff !== 1'h1 && c < 45000) begin
            wt(1);
            c++;
        end
        ck(c > 38000 && c < 41000, 1'h1, "delay length");
        want <= 6'h03;
        wt(3);
        ck(torque_cutoff, 1'h1, "manual hold");
        local_panel_reset <= 1'h1;
        wt(1);
        local_panel_reset <= 1'h0;
        wt(3);
        ck(torque_cutoff, 1'h0, "panel reset");
        internal_fault <= 1'h1;
        wt(1);
        internal_fault <= 1'h0;
        wt(2);
        ck({alarm, torque_cutoff}, 2'h3, "internal fault");
        apb(1'h1, `DSS_OFF_CMD, 32'h2);
        ck(alarm, 1'h1, "alarm kept");
        apb(1'h1, `DSS_OFF_CMD, 32'h3);
        wt(2);
        ck(alarm, 1'h0, "alarm clear");
        $display("test timed and alarm done");
        apb(1'h1, `DSS_OFF_CTRL, ctrl(`DSS_IN_CUTOFF, 1'h0, 1'h1, 1'h0));
        want <= 6'h01;
        wt(3);
        ck({ext_fault, torque_cutoff}, 2'h3, "discrepancy");
        want <= 6'h03;
        wt(3);
        ck(torque_cutoff, 1'h1, "ext needs reset");
        apb(1'h1, `DSS_OFF_CMD, 32'h2);
        wt(2);
        ck({ext_fault, torque_cutoff}, 2'h0, "ext reset");
        apb(1'h1, `DSS_OFF_CTRL, ctrl(`DSS_IN_CUTOFF, 1'h1, 1'h1, 1'h1));
        want <= 6'h23;
        wt(3);
        ck({ext_fault, timed_stop_then_cutoff}, 2'h3, "forced timed");
        $display("test external done");
        apb(1'h1, `DSS_OFF_CTRL, ctrl(`DSS_IN_CUTOFF, 1'h1, 1'h1, 1'h0) |
            (32'(`DSS_RSRC_DIN) << `DSS_CTRL_RSRC_LSB));
        want <= 6'h13;
        wt(3);
        ck({ext_fault, torque_cutoff}, 2'h3, "bus error");
        want <= 6'h03;
        wt(3);
        ck(torque_cutoff, 1'h1, "error needs reset");
        local_panel_reset <= 1'h1;
        wt(1);
        local_panel_reset <= 1'h0;
        wt(3);
        ck(torque_cutoff, 1'h1, "other source ignored");
        din_reset <= 1'h1;
        wt(1);
        din_reset <= 1'h0;
        wt(3);
        ck({ext_fault, torque_cutoff}, 2'h0, "input reset");
        apb(1'h0, `DSS_OFF_STATUS, 32'h0);
        ck(rd, 32'h0000_0010, "status run");
        apb(1'h1, `DSS_OFF_CTRL, ctrl(`DSS_IN_CUTOFF, 1'h0, 1'h0, 1'h0) |
            (32'(`DSS_RSRC_BUS) << `DSS_CTRL_RSRC_LSB));
        want <= 6'h00;
        wt(3);
        want <= 6'h03;
        wt(3);
        ck(torque_cutoff, 1'h1, "manual pending");
        plain_bus_reset <= 1'h1;
        wt(1);
        plain_bus_reset <= 1'h0;
        wt(3);
        ck(torque_cutoff, 1'h0, "plain bus reset");
        $display("test reset sources done");
        close_out;
    end
endmodule : dss_top_bench
